// file: rtl/timer_prescaler_pkg.sv
// Constants and types shared by the timer prescaler and clock-select block
package timer_prescaler_pkg;

  // Register byte offsets on the bus
  localparam logic [7:0] OFFSET_SYNC_CONTROL = 8'h00;
  localparam logic [7:0] OFFSET_CLOCK_CONTROL = 8'h04;
  localparam logic [7:0] OFFSET_STATUS = 8'h08;

  // Field positions in general_timer_sync_control
  localparam int BIT_PRESCALER_RESET_WIDE = 0;
  localparam int BIT_PRESCALER_RESET_ASYNC = 1;
  localparam int BIT_SYNC_HOLD_MODE = 7;

  // Field positions in the clock control register
  localparam int POS_CLOCK_SOURCE_SELECT = 0;
  localparam int BIT_ASYNC_MODE = 3;

  // Field positions in the status register
  localparam int POS_PRESCALER_COUNT = 0;
  localparam int BIT_PIN_SAMPLED = 16;
  localparam int BIT_ASYNC_DONE = 17;

  // Widths and values after reset
  localparam int PRESCALER_WIDTH = 10;
  localparam logic [9:0] PRESCALER_RESET_VALUE = 10'h000;
  localparam logic [7:0] SYNC_CONTROL_RESET_VALUE = 8'h00;

  // Prescaler tap masks: a tap fires when all masked count bits are one
  localparam logic [9:0] MASK_DIV8 = 10'h007;
  localparam logic [9:0] MASK_DIV64 = 10'h03F;
  localparam logic [9:0] MASK_DIV256 = 10'h0FF;
  localparam logic [9:0] MASK_DIV1024 = 10'h3FF;

  // Clock source select codes
  typedef enum logic [2:0] {
    CS_STOP = 3'h0,
    CS_DIRECT = 3'h1,
    CS_DIV8 = 3'h2,
    CS_DIV64 = 3'h3,
    CS_DIV256 = 3'h4,
    CS_DIV1024 = 3'h5,
    CS_EXT_FALL = 3'h6,
    CS_EXT_RISE = 3'h7
  } clock_source_e;

  // Captured bus address phase
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] offset;
  } bus_phase_s;

endpackage : timer_prescaler_pkg

// file: rtl/timer_prescaler_clock_select.sv
// Shared prescaler and clock-source select front end with AHB-Lite registers
//
// Function
// - Select one ticks every system clock
// - Prescaled taps divide by 8/64/256/1024
// - Prescaler runs regardless of select
// - First prescaled tick within 1 to N+1
// - Prescaler reset restarts all connected timers
// - Count pin sampled each clock, edge-detected
// - High-transparent latch before rising-edge registers
// - Select 7 rising, 6 falling pin edges
// - Pin edge reaches counter in 2.5-3.5 cycles
// - Pin ticks bypass the prescaler dividers
// - Async reset bit holds until reset done in async mode
// - Wide reset bit self-clears unless hold mode
// - Hold mode keeps written reset bits asserted
// - Clearing hold mode clears the wide reset bit; the async bit waits for reset done in async mode
// - No tick when no source selected
`timescale 1ns/10ps
module timer_prescaler_clock_select (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RESETN,
  // AHB-Lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic HREADYOUT,
  output logic [31:0] HRDATA,
  output logic HRESP,
  // External count pin and asynchronous timer handshake
  input wire logic EXTERNAL_COUNT_PIN,
  input wire logic ASYNC_RESET_DONE,
  // Timer side
  output logic TIMER_TICK,
  output logic PRESCALER_RESET_ASYNC_TIMER,
  output logic WIDE_TIMER_HALT
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release

  logic rst_meta;
  logic rst_n;

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave

  timer_prescaler_pkg::bus_phase_s phase;
  logic wr_sync;
  logic wr_clock;
  logic [31:0] next_rdata;

  logic sync_hold_mode;
  logic prescaler_reset_wide_timer;
  logic prescaler_reset_async_timer;
  logic async_mode;
  timer_prescaler_pkg::clock_source_e clock_source_select;
  logic [9:0] prescaler;
  logic pin_sync;
  logic async_done;

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      phase <= '0;
    end else if (HREADY) begin
      phase.valid <= HSEL && HTRANS[1];
      phase.write <= HWRITE;
      phase.offset <= HADDR[7:0];
    end
  end

  assign wr_sync = phase.valid && phase.write &&
                   (phase.offset == timer_prescaler_pkg::OFFSET_SYNC_CONTROL);
  assign wr_clock = phase.valid && phase.write &&
                    (phase.offset == timer_prescaler_pkg::OFFSET_CLOCK_CONTROL);

  always_comb begin
    next_rdata = 32'h00000000;
    case (HADDR[7:0])
      timer_prescaler_pkg::OFFSET_SYNC_CONTROL: begin
        next_rdata[timer_prescaler_pkg::BIT_SYNC_HOLD_MODE] = sync_hold_mode;
        next_rdata[timer_prescaler_pkg::BIT_PRESCALER_RESET_ASYNC] =
          prescaler_reset_async_timer;
        next_rdata[timer_prescaler_pkg::BIT_PRESCALER_RESET_WIDE] =
          prescaler_reset_wide_timer;
      end
      timer_prescaler_pkg::OFFSET_CLOCK_CONTROL: begin
        next_rdata[timer_prescaler_pkg::POS_CLOCK_SOURCE_SELECT +: 3] = clock_source_select;
        next_rdata[timer_prescaler_pkg::BIT_ASYNC_MODE] = async_mode;
      end
      timer_prescaler_pkg::OFFSET_STATUS: begin
        next_rdata[timer_prescaler_pkg::POS_PRESCALER_COUNT +: 10] = prescaler;
        next_rdata[timer_prescaler_pkg::BIT_PIN_SAMPLED] = pin_sync;
        next_rdata[timer_prescaler_pkg::BIT_ASYNC_DONE] = async_done;
      end
      default: begin
        next_rdata = 32'h00000000;
      end
    endcase
  end

  // Zero wait states: read data is fetched in the address phase
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      HRDATA <= 32'h00000000;
      HREADYOUT <= 1'b0;
      HRESP <= 1'b0;
    end else begin
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
      if (HREADY && HSEL && HTRANS[1] && !HWRITE) begin
        HRDATA <= next_rdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      clock_source_select <= timer_prescaler_pkg::CS_STOP;
      async_mode <= 1'b0;
    end else if (wr_clock) begin
      clock_source_select <= timer_prescaler_pkg::clock_source_e'(
        HWDATA[timer_prescaler_pkg::POS_CLOCK_SOURCE_SELECT +: 3]);
      async_mode <= HWDATA[timer_prescaler_pkg::BIT_ASYNC_MODE];
    end
  end

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      sync_hold_mode <= timer_prescaler_pkg::SYNC_CONTROL_RESET_VALUE[7];
    end else if (wr_sync) begin
      sync_hold_mode <= HWDATA[timer_prescaler_pkg::BIT_SYNC_HOLD_MODE];
    end
  end

  // A written one always wins over the hardware clear
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      prescaler_reset_wide_timer <= 1'b0;
    end else if (wr_sync) begin
      prescaler_reset_wide_timer <= HWDATA[timer_prescaler_pkg::BIT_PRESCALER_RESET_WIDE];
    end else if (!sync_hold_mode) begin
      prescaler_reset_wide_timer <= 1'b0;
    end
  end

  // Async completion arrives from another clock, so it is synchronised
  logic done_meta;

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      done_meta <= 1'b0;
      async_done <= 1'b0;
    end else begin
      done_meta <= ASYNC_RESET_DONE;
      async_done <= done_meta;
    end
  end

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      prescaler_reset_async_timer <= 1'b0;
    end else if (wr_sync) begin
      prescaler_reset_async_timer <= HWDATA[timer_prescaler_pkg::BIT_PRESCALER_RESET_ASYNC];
    end else if (!sync_hold_mode && (!async_mode || async_done)) begin
      prescaler_reset_async_timer <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared prescaler

  logic prescaler_clear;

  assign prescaler_clear = prescaler_reset_wide_timer || prescaler_reset_async_timer;

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      prescaler <= timer_prescaler_pkg::PRESCALER_RESET_VALUE;
    end else if (prescaler_clear) begin
      prescaler <= timer_prescaler_pkg::PRESCALER_RESET_VALUE;
    end else begin
      prescaler <= prescaler + 10'h001;
    end
  end

  function automatic logic [9:0] tap_mask(input timer_prescaler_pkg::clock_source_e sel);
    case (sel)
      timer_prescaler_pkg::CS_DIV8: tap_mask = timer_prescaler_pkg::MASK_DIV8;
      timer_prescaler_pkg::CS_DIV64: tap_mask = timer_prescaler_pkg::MASK_DIV64;
      timer_prescaler_pkg::CS_DIV256: tap_mask = timer_prescaler_pkg::MASK_DIV256;
      timer_prescaler_pkg::CS_DIV1024: tap_mask = timer_prescaler_pkg::MASK_DIV1024;
      default: tap_mask = 10'h000;
    endcase
  endfunction : tap_mask

  ////////////////////////////////////////////////////////////////////////////
  // Count pin synchroniser and edge detector

  logic pin_latch;
  logic pin_meta;
  logic pin_prev;

  always_latch begin
    if (CLOCK) begin
      pin_latch = EXTERNAL_COUNT_PIN;
    end
  end

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
      pin_prev <= 1'b0;
    end else begin
      pin_meta <= pin_latch;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock select and tick

  logic next_tick;
  logic [9:0] mask;

  assign mask = tap_mask(clock_source_select);

  always_comb begin
    next_tick = 1'b0;
    case (clock_source_select)
      timer_prescaler_pkg::CS_DIRECT: next_tick = 1'b1;
      timer_prescaler_pkg::CS_DIV8,
      timer_prescaler_pkg::CS_DIV64,
      timer_prescaler_pkg::CS_DIV256,
      timer_prescaler_pkg::CS_DIV1024: next_tick = ((prescaler & mask) == mask);
      timer_prescaler_pkg::CS_EXT_RISE: next_tick = pin_sync && !pin_prev;
      timer_prescaler_pkg::CS_EXT_FALL: next_tick = !pin_sync && pin_prev;
      default: next_tick = 1'b0;
    endcase
    if (prescaler_reset_wide_timer) begin
      next_tick = 1'b0;
    end
  end

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      TIMER_TICK <= 1'b0;
      PRESCALER_RESET_ASYNC_TIMER <= 1'b0;
      WIDE_TIMER_HALT <= 1'b0;
    end else begin
      TIMER_TICK <= next_tick;
      PRESCALER_RESET_ASYNC_TIMER <= prescaler_reset_async_timer;
      WIDE_TIMER_HALT <= prescaler_reset_wide_timer;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!rst_n);

  a_direct_tick_each: assert property (
    clock_source_select == timer_prescaler_pkg::CS_DIRECT && !prescaler_reset_wide_timer
    |=> TIMER_TICK) else $error("direct source missed a tick");

  a_stop_no_tick: assert property (
    clock_source_select == timer_prescaler_pkg::CS_STOP |=> !TIMER_TICK)
    else $error("tick with no source");

  a_prescaler_free_run: assert property (
    !prescaler_clear |=> prescaler == $past(prescaler) + 10'h001)
    else $error("prescaler did not advance");

  a_prescaler_phase_zero: assert property (
    prescaler_clear |=> prescaler == 10'h000) else $error("prescaler not cleared");

  a_rise_edge_tick: assert property (
    clock_source_select == timer_prescaler_pkg::CS_EXT_RISE && !prescaler_reset_wide_timer
    && pin_sync && !pin_prev |=> TIMER_TICK) else $error("rising edge lost");

  a_fall_edge_tick: assert property (
    clock_source_select == timer_prescaler_pkg::CS_EXT_FALL && pin_sync
    |=> !TIMER_TICK) else $error("tick on wrong edge");

  a_wide_self_clear: assert property (
    prescaler_reset_wide_timer && !sync_hold_mode && !wr_sync
    |=> !prescaler_reset_wide_timer ##1 !WIDE_TIMER_HALT) else $error("wide reset stuck");

  a_hold_keeps_bits: assert property (
    sync_hold_mode && prescaler_reset_wide_timer && !wr_sync
    |=> prescaler_reset_wide_timer) else $error("hold mode lost reset bit");

  a_async_waits_done: assert property (
    prescaler_reset_async_timer && async_mode && !async_done && !wr_sync
    |=> prescaler_reset_async_timer) else $error("async reset cleared early");

  c_direct_tick: cover property (
    clock_source_select == timer_prescaler_pkg::CS_DIRECT ##1 TIMER_TICK);
  c_hold_release: cover property ($fell(sync_hold_mode) ##1 !prescaler_reset_wide_timer);
  c_div8_tick: cover property (
    clock_source_select == timer_prescaler_pkg::CS_DIV8 ##1 TIMER_TICK);
  c_pin_rise_tick: cover property (
    clock_source_select == timer_prescaler_pkg::CS_EXT_RISE ##1 TIMER_TICK);

endmodule : timer_prescaler_clock_select

// file: verification/count_pin_source.sv
// Behavioural signal source driving the external count pin
`timescale 1ns/10ps
module count_pin_source (
  // Request
  input wire logic go,
  input wire logic [15:0] half_ns,
  input wire logic [7:0] count,
  // Pin side
  output logic pin,
  output logic busy
);
  initial begin
    pin = 1'b0;
    busy = 1'b0;
  end
  // half-periods chosen above one clock, pin idles low
  always @(posedge go) begin
    busy = 1'b1;
    #37;
    repeat (count) begin
      pin = 1'b1;
      #(half_ns);
      pin = 1'b0;
      #(half_ns);
    end
    busy = 1'b0;
  end
endmodule : count_pin_source

// file: verification/timer_prescaler_clock_select_tb.sv
// Self-checking bench for the prescaler and clock-select block
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin failures++; \
  $display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end
module timer_prescaler_clock_select_tb;
  logic CLOCK = 1'b0;
  logic RESETN = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hready, hresp, tick, rst_async, halt, pin, busy, done = 1'b0;
  logic [31:0] hrdata, rdv, a;
  logic go = 1'b0;
  logic [15:0] half = 16'h0;
  logic [7:0] cnt = 8'h0;
  int failures = 0;
  int n_checks = 0;
  int ticks = 0;
  int t0;
  timer_prescaler_clock_select dut (.CLOCK(CLOCK), .RESETN(RESETN), .HSEL(hsel),
    .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
    .HREADY(hready), .HREADYOUT(hready), .HRDATA(hrdata), .HRESP(hresp),
    .EXTERNAL_COUNT_PIN(pin), .ASYNC_RESET_DONE(done), .TIMER_TICK(tick),
    .PRESCALER_RESET_ASYNC_TIMER(rst_async), .WIDE_TIMER_HALT(halt));
  count_pin_source src (.go(go), .half_ns(half), .count(cnt), .pin(pin), .busy(busy));
  initial begin
    forever #50 CLOCK = ~CLOCK;
  end
  always @(posedge CLOCK) begin
    if (tick === 1'b1) ticks <= ticks + 1;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic bus(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, ad};
    hwrite <= wr;
    do @(posedge CLOCK); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge CLOCK); while (hready !== 1'b1);
    rdv = hrdata;
  endtask : bus
  task automatic rd(input logic [7:0] ad, input logic [31:0] e);
    bus(1'b0, ad, 32'h0);
    `CHK("read data", e, rdv)
    `CHK("response", 1'b0, hresp)
  endtask : rd
  // Tick count over a window must match
  task automatic win(input int n, input int e);
    t0 = ticks;
    repeat (n) @(posedge CLOCK);
    `CHK("ticks", e, ticks - t0)
  endtask : win
  task automatic pulses(input logic [15:0] h, input logic [7:0] c);
    half <= h;
    cnt <= c;
    go <= 1'b1;
    @(posedge CLOCK);
    go <= 1'b0;
    repeat (2000) if (busy === 1'b1) @(posedge CLOCK);
    repeat (8) @(posedge CLOCK);
  endtask : pulses
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (40000) @(posedge CLOCK);
    failures++;
    give_verdict;
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge CLOCK);
    RESETN <= 1'b1;
    repeat (4) @(posedge CLOCK);
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h0);
    bus(1'b1, 8'h0C, 32'hFF);
    rd(8'h0C, 32'h0);
    win(30, 0);
    bus(1'b0, 8'h08, 32'h0);
    a = rdv;
    repeat (20) @(posedge CLOCK);
    bus(1'b0, 8'h08, 32'h0);
    `CHK("free run", 10'd22, rdv[9:0] - a[9:0])
    bus(1'b1, 8'h04, 32'h1);
    // Select lands at the data edge and the tick flop adds one more
    repeat (2) @(posedge CLOCK);
    win(20, 20);
    bus(1'b1, 8'h00, 32'h1);
    // The bit reads one for exactly one cycle, then self-clears
    rd(8'h00, 32'h1);
    rd(8'h00, 32'h0);
    bus(1'b1, 8'h00, 32'h1);
    // Clear takes effect one edge after the bit is set
    @(posedge CLOCK);
    bus(1'b0, 8'h08, 32'h0);
    `CHK("restart", 10'h000, rdv[9:0])
    for (int s = 2; s < 6; s++) begin
      bus(1'b1, 8'h04, s);
      repeat (4) @(posedge CLOCK);
      win(2048, 2048 >> (3 + 3 * (s > 2) + 2 * (s > 3) + 2 * (s > 4)));
    end
    bus(1'b1, 8'h04, 32'h1);
    bus(1'b1, 8'h00, 32'h83);
    repeat (2) @(posedge CLOCK);
    `CHK("halt", 2'b11, {halt, rst_async})
    rd(8'h00, 32'h83);
    win(20, 0);
    rd(8'h08, 32'h0);
    bus(1'b1, 8'h00, 32'h0);
    repeat (2) @(posedge CLOCK);
    `CHK("release", 2'b00, {halt, rst_async})
    rd(8'h00, 32'h0);
    win(20, 20);
    bus(1'b1, 8'h04, 32'h9);
    bus(1'b1, 8'h00, 32'h2);
    repeat (4) @(posedge CLOCK);
    rd(8'h00, 32'h2);
    `CHK("async held", 1'b1, rst_async)
    done <= 1'b1;
    repeat (6) @(posedge CLOCK);
    rd(8'h00, 32'h0);
    `CHK("async free", 1'b0, rst_async)
    bus(1'b0, 8'h08, 32'h0);
    `CHK("done synced", 1'b1, rdv[17])
    done <= 1'b0;
    bus(1'b1, 8'h04, 32'h7);
    // Let the last direct-source ticks drain before counting pin ticks
    repeat (4) @(posedge CLOCK);
    t0 = ticks;
    pulses(16'd150, 8'd8);
    `CHK("rise ticks", 8, ticks - t0)
    bus(1'b1, 8'h04, 32'h6);
    t0 = ticks;
    pulses(16'd700, 8'd5);
    `CHK("fall ticks", 5, ticks - t0)
    give_verdict;
  end
endmodule : timer_prescaler_clock_select_tb
